// >>> logic/supply_droop_pkg.sv
// supply droop detector: register map, field positions, reset values, carriers
// assumes a byte-wide register port with 16-bit addresses
package supply_droop_pkg;

  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [15:0] CTRL_OFFSET = 16'hffbe;
  localparam logic [15:0] LEVEL_OFFSET = 16'hffbf;
  localparam logic [15:0] MASK_OFFSET = 16'hffc0;
  localparam logic [15:0] CAUSE_OFFSET = 16'hffc1;

  // ****************************************************
  // fields
  // ****************************************************
  localparam int ENABLE_BIT = 7;
  localparam int REFERENCE_BIT = 4;
  localparam int MODE_BIT = 1;
  localparam int FLAG_BIT = 0;
  localparam int MASK_BIT = 0;
  localparam int CAUSE_DROOP_BIT = 0;
  localparam int LEVEL_MSB = 2;
  localparam logic [2:0] LEVEL_PROHIBITED = 3'h7;

  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] LEVEL_RESET = 3'h0;
  localparam logic MASK_RESET = 1'b1;
  localparam logic [7:0] CAUSE_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ****************************************************
  // carriers
  // ****************************************************
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef struct packed {
    logic detector_enable;
    logic reference_enable;
    logic [2:0] level;
  } analog_ctrl_type;

endpackage

// >>> logic/droop_sync.sv
// two-stage synchroniser for the analog comparator outputs
// assumes inputs may change at any time relative to clock
`timescale 1ns/100ps
module droop_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // first stage is read only by the second stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// >>> logic/reset_cause_keeper.sv
// reset-cause register: sticky cause bits, wiped by power-on-clear
// assumes set and clear inputs are synchronous to clock
`timescale 1ns/100ps
module reset_cause_keeper (
  input wire logic clock,
  input wire logic rst,
  input wire logic droop_set,
  input wire logic poc_clear,
  input wire logic [6:0] other_set,
  output logic [7:0] cause_q
);
  import supply_droop_pkg::*;

  logic [7:0] cause_d;

  // a set in the clearing cycle survives
  always_comb begin
    cause_d = poc_clear ? CAUSE_RESET : cause_q;
    cause_d = cause_d | {other_set, 1'b0};
    cause_d[CAUSE_DROOP_BIT] = cause_d[CAUSE_DROOP_BIT] | droop_set;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cause_q <= CAUSE_RESET;
    end else begin
      cause_q <= cause_d;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_poc_wipes_cause: assert property (
    poc_clear && !droop_set && other_set == 7'h00 |=> cause_q == 8'h00)
    else $error("power-on-clear did not wipe cause");
  a_droop_sets_cause: assert property (
    droop_set |=> cause_q[CAUSE_DROOP_BIT] ##1 cause_q[CAUSE_DROOP_BIT]
      || $past(poc_clear, 1) || poc_clear)
    else $error("droop cause flag not kept");

endmodule

// >>> logic/supply_droop_detector.sv
// supply droop detector control: registers, flag, interrupt and reset
// assumes analog comparators outside, and a system reset/interrupt unit
//
// Behaviour
// - power-on-clear comparator low holds internal reset for as long as it lasts
// - external reset clears the whole control register to zero
// - droop reset keeps enable, reference and mode; other resets clear them
// - external reset clears the level-select register to zero
// - enable bit 7 starts the comparator; clearing it stops detection
// - bit 4 enables reference; ignored when power-on-clear is fitted
// - read-only flag bit 0 is 1 below level, else 0 or when disabled
// - mode bit 1: zero asks interrupt, one asks internal reset
// - interrupt request follows flag only while enabled and mode is zero
// - level bits 2..0 pick one of seven thresholds; code seven prohibited
// - setting reset mode while supply is above level gives no reset
// - droop-caused reset sets cause flag bit 0 of reset-cause register
// - detection, interrupt and reset keep working in stop mode
// - external reset sets the droop interrupt mask to one
// - power-on-clear reset wipes the whole reset-cause register
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
module supply_droop_detector #(
  parameter bit POC_FITTED = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire supply_droop_pkg::bus_req_type bus_req,
  output logic [7:0] read_data,
  input wire logic droop_below_raw,
  input wire logic poc_below_raw,
  input wire logic other_reset_raw,
  input wire logic [6:0] other_cause_set,
  output supply_droop_pkg::analog_ctrl_type analog_ctrl,
  output logic below_threshold_flag,
  output logic droop_interrupt_request,
  output logic droop_interrupt_mask,
  output logic internal_reset,
  output logic [7:0] reset_cause_register
);
  import supply_droop_pkg::*;

  // ****************************************************
  // decode
  // ****************************************************
  function automatic logic reg_hit(
    input logic [15:0] addr,
    input logic [15:0] offset
  );
    reg_hit = (addr == offset);
  endfunction

  logic ctrl_wr;
  logic level_wr;
  logic mask_wr;

  assign ctrl_wr = bus_req.wr && reg_hit(bus_req.addr, CTRL_OFFSET);
  assign level_wr = bus_req.wr && reg_hit(bus_req.addr, LEVEL_OFFSET);
  assign mask_wr = bus_req.wr && reg_hit(bus_req.addr, MASK_OFFSET);

  // ****************************************************
  // comparator synchronisation
  // ****************************************************
  logic droop_s;
  logic poc_s;
  logic other_s;

  droop_sync #(
    .WIDTH(3)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .async_in({droop_below_raw, poc_below_raw, other_reset_raw}),
    .sync_out({droop_s, poc_s, other_s})
  );

  // ****************************************************
  // control and level registers
  // ****************************************************
  logic enable_q;
  logic enable_d;
  logic reference_q;
  logic reference_d;
  logic mode_q;
  logic mode_d;
  logic [2:0] level_q;
  logic [2:0] level_d;
  logic mask_d;
  logic foreign_reset;

  // a droop reset is not foreign, so it leaves the control bits alone
  assign foreign_reset = poc_s || other_s;

  always_comb begin
    enable_d = enable_q;
    reference_d = reference_q;
    mode_d = mode_q;
    if (ctrl_wr) begin
      enable_d = bus_req.wdata[ENABLE_BIT];
      mode_d = bus_req.wdata[MODE_BIT];
      if (!POC_FITTED) begin
        reference_d = bus_req.wdata[REFERENCE_BIT];
      end
    end
    if (foreign_reset) begin
      enable_d = 1'b0;
      reference_d = 1'b0;
      mode_d = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enable_q <= CTRL_RESET[ENABLE_BIT];
      reference_q <= CTRL_RESET[REFERENCE_BIT];
      mode_q <= CTRL_RESET[MODE_BIT];
    end else begin
      enable_q <= enable_d;
      reference_q <= reference_d;
      mode_q <= mode_d;
    end
  end

  // the prohibited code is refused; the previous level stays in force
  always_comb begin
    level_d = level_q;
    if (level_wr && bus_req.wdata[LEVEL_MSB:0] != LEVEL_PROHIBITED) begin
      level_d = bus_req.wdata[LEVEL_MSB:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      level_q <= LEVEL_RESET;
    end else begin
      level_q <= level_d;
    end
  end

  always_comb begin
    mask_d = droop_interrupt_mask;
    if (mask_wr) begin
      mask_d = bus_req.wdata[MASK_BIT];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      droop_interrupt_mask <= MASK_RESET;
    end else begin
      droop_interrupt_mask <= mask_d;
    end
  end

  // ****************************************************
  // analog side
  // ****************************************************
  // reference is forced on when power-on-clear shares it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      analog_ctrl <= '0;
    end else begin
      analog_ctrl.detector_enable <= enable_d;
      analog_ctrl.reference_enable <= reference_d || POC_FITTED;
      analog_ctrl.level <= level_d;
    end
  end

  // ****************************************************
  // flag, interrupt request and reset request
  // ****************************************************
  // nothing here looks at a stop mode, so all of it keeps running
  logic flag_d;
  logic irq_d;
  logic droop_reset_d;

  assign flag_d = enable_q && droop_s;
  assign irq_d = flag_d && !mode_q;
  // reset only on a real droop, never on the mode write itself
  assign droop_reset_d = flag_d && mode_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      below_threshold_flag <= 1'b0;
      droop_interrupt_request <= 1'b0;
    end else begin
      below_threshold_flag <= flag_d;
      droop_interrupt_request <= irq_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      internal_reset <= 1'b0;
    end else begin
      internal_reset <= poc_s || droop_reset_d;
    end
  end

  // ****************************************************
  // reset cause
  // ****************************************************
  reset_cause_keeper u_cause (
    .clock(clock),
    .rst(rst),
    .droop_set(droop_reset_d),
    .poc_clear(poc_s),
    .other_set(other_cause_set),
    .cause_q(reset_cause_register)
  );

  // ****************************************************
  // read port
  // ****************************************************
  logic [7:0] read_d;

  // unmapped addresses read zero
  always_comb begin
    read_d = READ_ZERO;
    if (bus_req.rd) begin
      case (bus_req.addr)
        CTRL_OFFSET: begin
          read_d[ENABLE_BIT] = enable_q;
          read_d[REFERENCE_BIT] = reference_q;
          read_d[MODE_BIT] = mode_q;
          read_d[FLAG_BIT] = below_threshold_flag;
        end
        LEVEL_OFFSET: begin
          read_d[LEVEL_MSB:0] = level_q;
        end
        MASK_OFFSET: begin
          read_d[MASK_BIT] = droop_interrupt_mask;
        end
        CAUSE_OFFSET: begin
          read_d = reset_cause_register;
        end
        default: begin
          read_d = READ_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      read_data <= READ_ZERO;
    end else begin
      read_data <= read_d;
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  logic started_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // one cycle behind the synchronised comparator, for as long as it stays low
  a_poc_holds_reset: assert property (
    poc_s |=> internal_reset)
    else $error("internal reset dropped during power-on-clear");
  a_reset_values: assert property (
    !started_q |-> !enable_q && !reference_q && !mode_q
      && level_q == 3'h0 && droop_interrupt_mask)
    else $error("wrong values after external reset");
  a_droop_keeps_bits: assert property (
    droop_reset_d && !foreign_reset && !ctrl_wr
      |=> enable_q && mode_q && $stable(reference_q))
    else $error("droop reset disturbed control bits");
  a_foreign_clears_bits: assert property (
    foreign_reset |=> !enable_q && !reference_q && !mode_q)
    else $error("foreign reset left control bits set");
  a_enable_write: assert property (
    ctrl_wr && !foreign_reset
      |=> enable_q == $past(bus_req.wdata[ENABLE_BIT]))
    else $error("enable bit not written");
  a_flag_source: assert property (
    enable_q && droop_s |=> below_threshold_flag)
    else $error("flag missed a droop");
  a_flag_off_disabled: assert property (
    !enable_q |=> !below_threshold_flag)
    else $error("flag set while disabled");
  a_irq_in_mode: assert property (
    droop_interrupt_request |-> below_threshold_flag && $past(!mode_q))
    else $error("interrupt outside interrupt mode");
  a_level_legal: assert property (
    level_q != LEVEL_PROHIBITED)
    else $error("prohibited level stored");
  a_no_reset_above: assert property (
    !droop_s && !poc_s |=> !internal_reset)
    else $error("reset without low supply");
  a_sync_latency: assert property (
    enable_q && mode_q && !ctrl_wr && !foreign_reset && !droop_s
      ##1 droop_s |-> !internal_reset)
    else $error("droop reached reset too early");
  a_droop_to_cause: assert property (
    droop_reset_d |=> reset_cause_register[CAUSE_DROOP_BIT])
    else $error("cause flag not set by droop reset");

  c_interrupt_fires: cover property (
    !droop_interrupt_mask ##1 droop_interrupt_request);
  c_droop_reset: cover property (
    mode_q && droop_s ##2 internal_reset);
  c_poc_reset: cover property (poc_s ##1 internal_reset ##1 !poc_s);

endmodule

// >>> dv/supply_comparator_model.sv
// partner: analog supply comparators behind the droop detector
// assumes supply level in millivolts driven by the bench
`timescale 1ns/100ps
module supply_comparator_model
  import supply_droop_pkg::*;
#(
  parameter int POC_MV = 2850
) (
  input var int supply_mv,
  input wire supply_droop_pkg::analog_ctrl_type analog_ctrl,
  output logic droop_below_raw,
  output logic poc_below_raw
);
  int thr [7] = '{4300, 4100, 3900, 3700, 3500, 3300, 3100};
  always_comb begin
    // an idle comparator gives low, so a stale droop cannot leak through
    droop_below_raw = analog_ctrl.detector_enable && analog_ctrl.level != 3'h7
      && supply_mv < thr[analog_ctrl.level];
    poc_below_raw = supply_mv < POC_MV;
  end
endmodule

// >>> dv/low_voltage_detect_control_tb_top.sv
// testbench: register port, flag, interrupt, reset and cause paths
// assumes power-on-clear fitted and the comparator model beside the design
`timescale 1ns/100ps
module low_voltage_detect_control_tb_top;
  import supply_droop_pkg::*;
  localparam int POC_MV = 2850;
  logic clock = 1'b0;
  logic rst = 1'b1;
  bus_req_type bus_req = '0;
  logic [7:0] read_data;
  logic droop_below_raw;
  logic poc_below_raw;
  logic other_reset_raw = 1'b0;
  logic [6:0] other_cause_set = 7'h00;
  analog_ctrl_type analog_ctrl;
  logic below_threshold_flag;
  logic droop_interrupt_request;
  logic droop_interrupt_mask;
  logic internal_reset;
  logic [7:0] reset_cause_register;
  int supply_mv = 5000;
  int err_total = 0;
  int n_compared = 0;
  int en = 0;
  int mode = 0;
  int lvl = 0;
  int cause = 0;
  int below = 0;
  int r;
  int thr [7] = '{4300, 4100, 3900, 3700, 3500, 3300, 3100};

  always #2.5 clock = ~clock;

  supply_droop_detector #(.POC_FITTED(1'b1)) dut_u (
    .clock(clock),
    .rst(rst),
    .bus_req(bus_req),
    .read_data(read_data),
    .droop_below_raw(droop_below_raw),
    .poc_below_raw(poc_below_raw),
    .other_reset_raw(other_reset_raw),
    .other_cause_set(other_cause_set),
    .analog_ctrl(analog_ctrl),
    .below_threshold_flag(below_threshold_flag),
    .droop_interrupt_request(droop_interrupt_request),
    .droop_interrupt_mask(droop_interrupt_mask),
    .internal_reset(internal_reset),
    .reset_cause_register(reset_cause_register)
  );

  supply_comparator_model #(.POC_MV(POC_MV)) cmp_u (
    .supply_mv(supply_mv),
    .analog_ctrl(analog_ctrl),
    .droop_below_raw(droop_below_raw),
    .poc_below_raw(poc_below_raw)
  );

  // ****************************************************
  // shared tasks
  // ****************************************************
  task automatic tally_and_finish();
    if (err_total == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp,
                    input string what);
    @(posedge clock);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1 chk(what, exp, read_data);
  endtask

  function automatic logic [7:0] ctrl_exp();
    // reference bit reads 0 while power-on-clear is fitted
    return {en[0], 5'h00, mode[0], 1'(en != 0 && below != 0)};
  endfunction

  // comparator edge plus two sync flops plus output register
  task automatic settle(input int v);
    @(posedge clock);
    supply_mv <= v;
    repeat (4) @(posedge clock);
    below = (v < thr[lvl]) ? 1 : 0;
    if (en != 0 && mode != 0 && below != 0) cause = cause | 1;
    if (v < POC_MV) cause = 0;
    #1;
    chk("flag", 8'(en != 0 && below != 0), 8'(below_threshold_flag));
    chk("irq", 8'(en != 0 && mode == 0 && below != 0),
        8'(droop_interrupt_request));
    chk("ireset", 8'(v < POC_MV || (en != 0 && mode != 0 && below != 0)),
        8'(internal_reset));
    chk("cause", 8'(cause), reset_cause_register);
    chk("lvl", 8'(lvl), 8'(analog_ctrl.level));
    chk("det", 8'(en), 8'(analog_ctrl.detector_enable));
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    void'($urandom(48090));
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1 chk("ref", 8'h01, 8'(analog_ctrl.reference_enable));
    chk("mask", 8'h01, 8'(droop_interrupt_mask));
    rd(CTRL_OFFSET, 8'h00, "ctrl");
    rd(LEVEL_OFFSET, 8'h00, "level");
    rd(CAUSE_OFFSET, 8'h00, "cause");
    rd(16'hffc2, 8'h00, "unmapped");
    wr(MASK_OFFSET, 8'h01);
    wr(CTRL_OFFSET, 8'h10);
    rd(CTRL_OFFSET, 8'h00, "ctrl ref");
    en = 1;
    wr(CTRL_OFFSET, 8'h80);
    for (int i = 0; i < 8; i++) begin
      wr(LEVEL_OFFSET, 8'(i));
      if (i != 7) lvl = i;
      rd(LEVEL_OFFSET, 8'(lvl), "level");
      settle(thr[lvl] + int'($urandom_range(400)) - 200);
      rd(CTRL_OFFSET, ctrl_exp(), "ctrl flag");
    end
    wr(LEVEL_OFFSET, 8'hfa);
    lvl = 2;
    rd(LEVEL_OFFSET, 8'h02, "level upper");
    settle(5000);
    wr(MASK_OFFSET, 8'h00);
    rd(MASK_OFFSET, 8'h00, "mask");
    mode = 1;
    wr(CTRL_OFFSET, 8'hff);
    rd(CTRL_OFFSET, ctrl_exp(), "ctrl mode");
    settle(5000);
    settle(thr[lvl] - 100);
    rd(CTRL_OFFSET, ctrl_exp(), "ctrl kept");
    settle(5000);
    en = 0;
    mode = 0;
    wr(CTRL_OFFSET, 8'h00);
    settle(thr[lvl] - 100);
    settle(5000);
    wr(CAUSE_OFFSET, 8'hff);
    r = $urandom_range(127);
    @(posedge clock);
    other_cause_set <= 7'(r);
    @(posedge clock);
    other_cause_set <= 7'h00;
    cause = cause | (r << 1);
    rd(CAUSE_OFFSET, 8'(cause), "cause other");
    en = 1;
    mode = 1;
    wr(CTRL_OFFSET, 8'h82);
    @(posedge clock);
    other_reset_raw <= 1'b1;
    repeat (3) @(posedge clock);
    other_reset_raw <= 1'b0;
    repeat (4) @(posedge clock);
    en = 0;
    mode = 0;
    rd(CTRL_OFFSET, 8'h00, "ctrl other");
    settle(POC_MV - 300);
    settle(5000);
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    lvl = 0;
    rd(LEVEL_OFFSET, 8'h00, "level rst");
    rd(CTRL_OFFSET, 8'h00, "ctrl rst");
    rd(MASK_OFFSET, 8'h01, "mask rst");
    tally_and_finish();
  end

  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end
endmodule
